// ### hdl/runaway_code_watchdog.sv
// watchdog top: register slave, disable logic, reset pulse and cause flag
//
// Function
// RL1: 6-bit counter fed by 12-bit shared prescaler
// RL2: clocked by crystal clock only
// RL3: overflow resets after 8176 or 262128 cycles
// RL4: service register decoded at index ffff
// RL5: any service write clears counter, restarts timeout
// RL6: service clears prescaler stages 12..5 (conflict resolved)
// RL7: service read returns reset vector low byte
// RL8: reset pin low 32 cycles, cause flag set
// RL9: stop instruction clears the prescaler
// RL10: prescaler cleared 4096 cycles after power-up
// RL11: internal reset clears prescaler and counter
// RL12: reset vector fetch clears the prescaler
// RL13: disable option suppresses watchdog resets
// RL14: rate option selects between two timeouts
// RL15: monitor mode test voltage disables watchdog
// RL16: break state with test voltage disables
// RL17: no CPU interrupt, only system reset
// RL18: software services promptly, from main program
// RL19: stop mode removes clock, clears prescaler
// RL20: wait mode keeps counting, resets at timeout
// RL21: disabled holds counter clear, suppresses reset
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module runaway_code_watchdog #(
  parameter int         RESET_PIN_CYCLES = wdog_pkg::RESET_PIN_CYCLES,
  parameter int         POR_CLEAR_CYCLES = wdog_pkg::POR_CLEAR_CYCLES,
  parameter logic [7:0] RESET_VECTOR_LOW = 8'h00  // low byte of the reset vector
) (
  // clock is the crystal clock, reset synchronous active low
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // write address channel
  input  wire logic [wdog_pkg::ADDR_W-1:0] awaddr,
  input  wire logic [2:0]                  awprot,
  input  wire logic                        awvalid,
  output logic                             awready,
  // write data channel
  input  wire logic [wdog_pkg::DATA_W-1:0] wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  // write response channel
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  // read address channel
  input  wire logic [wdog_pkg::ADDR_W-1:0] araddr,
  input  wire logic [2:0]                  arprot,
  input  wire logic                        arvalid,
  output logic                             arready,
  // read data channel
  output logic [wdog_pkg::DATA_W-1:0]      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  // cpu and system integration events
  input  wire logic                        stop_mode,
  input  wire logic                        vector_fetch,
  input  wire logic                        internal_reset,
  input  wire logic                        monitor_mode,
  input  wire logic                        break_state,
  input  wire logic                        test_high_voltage_on_reset,
  input  wire logic                        test_high_voltage_on_irq,
  // open-drain reset pin
  input  wire logic                        reset_pin_i,
  output logic                             reset_pin_o,
  output logic                             reset_pin_oe,
  // system reset and cause
  output logic                             system_reset,
  output logic                             watchdog_cause
);

  // widths of the local counters
  localparam int PULSE_W = $clog2(RESET_PIN_CYCLES);
  localparam int POR_W   = $clog2(POR_CLEAR_CYCLES + 1);
  localparam logic [PULSE_W-1:0] PULSE_LOAD = PULSE_W'(RESET_PIN_CYCLES - 1);
  localparam logic [POR_W-1:0]   POR_LAST   = POR_W'(POR_CLEAR_CYCLES - 1);
  localparam logic [POR_W-1:0]   POR_DONE   = POR_W'(POR_CLEAR_CYCLES);

  // address decode shared by the read and write paths
  function automatic wdog_pkg::reg_sel_t decode_reg(input logic [wdog_pkg::ADDR_W-1:0] addr);
    if (addr == wdog_pkg::SERVICE_ADDR) begin       // see RL4
      return wdog_pkg::SEL_SERVICE;
    end else if (addr == wdog_pkg::CONTROL_ADDR) begin
      return wdog_pkg::SEL_CONTROL;
    end else if (addr == wdog_pkg::STATUS_ADDR) begin
      return wdog_pkg::SEL_STATUS;
    end else begin
      return wdog_pkg::SEL_NONE;
    end
  endfunction : decode_reg

  // ---- state ----
  logic [wdog_pkg::ADDR_W-1:0] wr_addr;       // captured write address
  logic [wdog_pkg::DATA_W-1:0] wr_data;       // captured write data
  logic [3:0]                  wr_strb;       // captured byte strobes
  wdog_pkg::wdog_ctrl_t        ctrl;          // software control bits
  wdog_pkg::wd_state_t         state;         // sequencer state
  wdog_pkg::wd_state_t         next_state;
  logic [PULSE_W-1:0]          pulse_count;   // reset pin cycles left
  logic [PULSE_W-1:0]          next_pulse_count;
  logic [POR_W-1:0]            por_count;     // cycles since power-up
  logic                        next_cause;    // next cause flag value
  logic                        pin_level;     // sampled reset pin

  // ---- decode and control wires ----
  wdog_pkg::reg_sel_t          wr_sel;        // write target
  wdog_pkg::reg_sel_t          rd_sel;        // read target
  logic                        wr_fire;       // both write halves held
  logic                        aw_take;       // write address handshake
  logic                        w_take;        // write data handshake
  logic                        b_done;        // write response handshake
  logic                        ar_take;       // read address handshake
  logic                        r_done;        // read data handshake
  logic                        service_write; // service strobe
  logic                        ctrl_write;    // control register strobe
  logic                        cause_clear;   // software clear of cause flag
  logic                        test_disable;  // test voltage hold-off
  logic                        eff_disable;   // watchdog held off
  logic                        wd_fire;       // overflow accepted
  logic                        por_clear;     // one-shot power-up clear
  logic [wdog_pkg::DATA_W-1:0] status_word;   // assembled status
  logic [wdog_pkg::DATA_W-1:0] read_word;     // read mux output
  wdog_pkg::wdog_clear_t       clears;        // clear requests to the chain
  wdog_pkg::wdog_count_t       chain;         // counter chain state

  // ---- bus handshakes ----
  assign aw_take = awvalid & awready;
  assign w_take  = wvalid & wready;
  assign b_done  = bvalid & bready;
  assign ar_take = arvalid & arready;
  assign r_done  = rvalid & rready;
  // write goes ahead once both halves are held and no response is pending
  assign wr_fire = ~awready & ~wready & ~bvalid;

  // ---- register decode ----
  assign wr_sel        = decode_reg(wr_addr);
  assign rd_sel        = decode_reg(araddr);
  // any value, any byte lanes, restarts the timeout (see RL5)
  assign service_write = wr_fire & (wr_sel == wdog_pkg::SEL_SERVICE);
  assign ctrl_write    = wr_fire & (wr_sel == wdog_pkg::SEL_CONTROL) & wr_strb[0];
  assign cause_clear   = wr_fire & (wr_sel == wdog_pkg::SEL_STATUS) & wr_strb[0]
                       & wr_data[wdog_pkg::STAT_CAUSE_BIT];

  // ---- disable sources ----
  // test voltage on either pin in monitor mode, or on the reset pin in break state, holds the watchdog off
  assign test_disable = (monitor_mode & (test_high_voltage_on_reset | test_high_voltage_on_irq))
                      | (break_state & test_high_voltage_on_reset); // see RL15 see RL16
  assign eff_disable  = ctrl.disable_opt | test_disable;            // see RL13

  // overflow only counts while running and enabled; wait mode changes nothing (see RL20)
  assign wd_fire = (state == wdog_pkg::ST_COUNTING) & ~eff_disable & chain.timeout; // see RL3

  // ---- power-up clear ----
  assign por_clear = por_count == POR_LAST; // see RL10

  // ---- clear requests ----
  assign clears.stop_mode      = stop_mode;       // see RL9 see RL19
  assign clears.vector_fetch   = vector_fetch;    // see RL12
  assign clears.por_clear      = por_clear;
  assign clears.internal_reset = internal_reset;  // see RL11
  // held clear while disabled or while our own reset runs (see RL21)
  assign clears.hold_clear     = eff_disable | (state != wdog_pkg::ST_COUNTING);
  assign clears.service        = service_write;

  // ---- cause flag: set wins over the software clear ----
  assign next_cause = wd_fire | (watchdog_cause & ~cause_clear); // see RL8

  // ---- status and read mux ----
  always_comb begin
    status_word = '0;
    status_word[wdog_pkg::STAT_CAUSE_BIT]    = watchdog_cause;
    status_word[wdog_pkg::STAT_ACTIVE_BIT]   = state == wdog_pkg::ST_RESET_OUT;
    status_word[wdog_pkg::STAT_DISABLED_BIT] = eff_disable;
    status_word[wdog_pkg::STAT_PIN_BIT]      = pin_level;
    status_word[wdog_pkg::STAT_COUNT_LSB +: wdog_pkg::COUNTER_W]   = chain.count;
    status_word[wdog_pkg::STAT_PRESC_LSB +: wdog_pkg::PRESCALER_W] = chain.prescaler;
  end

  // service read returns the vector byte and touches nothing (see RL7)
  always_comb begin
    read_word = '0;
    unique case (rd_sel)
      wdog_pkg::SEL_SERVICE: read_word[7:0] = RESET_VECTOR_LOW;
      wdog_pkg::SEL_CONTROL: begin
        read_word[wdog_pkg::CTRL_DISABLE_BIT] = ctrl.disable_opt;
        read_word[wdog_pkg::CTRL_RATE_BIT]    = ctrl.rate_long;
      end
      wdog_pkg::SEL_STATUS:  read_word = status_word;
      wdog_pkg::SEL_NONE:    read_word = '0;
    endcase
  end

  // ---- sequencer next state ----
  always_comb begin
    next_state       = state;
    next_pulse_count = pulse_count;
    unique case (state)
      // running: go quiet when disabled, start the pulse on overflow
      wdog_pkg::ST_COUNTING: begin
        if (eff_disable) begin
          next_state = wdog_pkg::ST_DISABLED;
        end else if (wd_fire) begin
          next_state       = wdog_pkg::ST_RESET_OUT; // see RL8
          next_pulse_count = PULSE_LOAD;
        end
      end
      // held off: restart from zero once released
      wdog_pkg::ST_DISABLED: begin
        if (!eff_disable) begin
          next_state = wdog_pkg::ST_COUNTING;
        end
      end
      // pulse: hold the reset for the full pin time
      wdog_pkg::ST_RESET_OUT: begin
        if (pulse_count == '0) begin
          next_state = wdog_pkg::ST_COUNTING;
        end else begin
          next_pulse_count = pulse_count - PULSE_W'(1);
        end
      end
      default: begin
        next_state = wdog_pkg::ST_COUNTING;
      end
    endcase
  end

  // ---- write address and data capture ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wr_addr <= '0;
    end else if (aw_take) begin
      awready <= 1'b0;
      wr_addr <= awaddr;
    end else if (b_done) begin
      awready <= 1'b1;
    end
  end

  // data half, taken independently of the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready  <= 1'b1;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (w_take) begin
      wready  <= 1'b0;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end else if (b_done) begin
      wready  <= 1'b1;
    end
  end

  // ---- write response ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= wdog_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= (wr_sel == wdog_pkg::SEL_NONE) ? wdog_pkg::RESP_SLVERR : wdog_pkg::RESP_OKAY;
    end else if (b_done) begin
      bvalid <= 1'b0;
    end
  end

  // ---- read channel: data registered at the address handshake ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= wdog_pkg::RESP_OKAY;
    end else if (ar_take) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= read_word;
      rresp   <= (rd_sel == wdog_pkg::SEL_NONE) ? wdog_pkg::RESP_SLVERR : wdog_pkg::RESP_OKAY;
    end else if (r_done) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
    end
  end

  // ---- control register ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl.disable_opt <= wdog_pkg::CTRL_DISABLE_RST;
      ctrl.rate_long   <= wdog_pkg::CTRL_RATE_RST;
    end else if (ctrl_write) begin
      ctrl.disable_opt <= wr_data[wdog_pkg::CTRL_DISABLE_BIT]; // see RL13
      ctrl.rate_long   <= wr_data[wdog_pkg::CTRL_RATE_BIT];    // see RL14
    end
  end

  // ---- power-up counter, stops once the clear has fired ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_count <= '0;
    end else if (por_count != POR_DONE) begin
      por_count <= por_count + POR_W'(1);
    end
  end

  // ---- sequencer and reset pulse ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state       <= wdog_pkg::ST_COUNTING;
      pulse_count <= '0;
    end else begin
      state       <= next_state;
      pulse_count <= next_pulse_count;
    end
  end

  // ---- registered outputs; the only action is a reset, never an interrupt ----
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_reset   <= 1'b0;
      reset_pin_oe   <= 1'b0;
      reset_pin_o    <= 1'b0;
      watchdog_cause <= 1'b0;
      pin_level      <= 1'b1;
    end else begin
      system_reset   <= next_state == wdog_pkg::ST_RESET_OUT; // see RL17
      reset_pin_oe   <= next_state == wdog_pkg::ST_RESET_OUT; // see RL8
      reset_pin_o    <= 1'b0;
      watchdog_cause <= next_cause;
      pin_level      <= reset_pin_i;
    end
  end

  // ---- counter chain ----
  timeout_counter #(
    .PRESCALER_W (wdog_pkg::PRESCALER_W),
    .COUNTER_W   (wdog_pkg::COUNTER_W)
  ) u_chain (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .rate_long (ctrl.rate_long),
    .clears    (clears),
    .state     (chain)
  );

endmodule : runaway_code_watchdog

// ### hdl/timeout_counter.sv
// prescaler and watchdog counter chain with timeout detection
`timescale 1ns/1ps

module timeout_counter #(
  parameter int PRESCALER_W = wdog_pkg::PRESCALER_W,
  parameter int COUNTER_W   = wdog_pkg::COUNTER_W
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 rate_long,
  input  wire wdog_pkg::wdog_clear_t clears,
  output wdog_pkg::wdog_count_t     state
);

  // tap and fire points for both rates
  localparam logic [PRESCALER_W-1:0] SHORT_LAST = PRESCALER_W'(wdog_pkg::SHORT_PERIOD - 1);
  localparam logic [PRESCALER_W-1:0] LONG_LAST  = PRESCALER_W'(wdog_pkg::LONG_PERIOD - 1);
  localparam logic [PRESCALER_W-1:0] SHORT_FIRE =
    PRESCALER_W'(wdog_pkg::SHORT_PERIOD - wdog_pkg::TIMEOUT_TRIM);
  localparam logic [PRESCALER_W-1:0] LONG_FIRE  =
    PRESCALER_W'(wdog_pkg::LONG_PERIOD - wdog_pkg::TIMEOUT_TRIM);
  localparam logic [PRESCALER_W-1:0] KEEP_MASK  =
    PRESCALER_W'((1 << wdog_pkg::SERVICE_CLEAR_LSB) - 1);

  logic [PRESCALER_W-1:0] prescaler;        // shared prescaler
  logic [PRESCALER_W-1:0] next_prescaler;
  logic [COUNTER_W-1:0]   count;            // watchdog counter
  logic [COUNTER_W-1:0]   next_count;
  logic [PRESCALER_W-1:0] low_bits;         // prescaler stages below the selected tap
  logic                   tick;             // counter advance
  logic                   full_clear;       // whole prescaler clear

  // rate select picks the tap feeding the counter (see RL14)
  assign low_bits = rate_long ? prescaler : (prescaler & SHORT_LAST);
  assign tick     = low_bits == (rate_long ? LONG_LAST : SHORT_LAST); // see RL1

  // overflow lands 8176 or 262128 cycles after a full clear (see RL3)
  assign state.timeout   = (count == '1) && (low_bits == (rate_long ? LONG_FIRE : SHORT_FIRE));
  assign state.prescaler = prescaler;
  assign state.count     = count;

  // prescaler clears: stop, vector fetch, power-up, internal reset, hold
  assign full_clear = clears.stop_mode | clears.vector_fetch | clears.por_clear
                    | clears.internal_reset | clears.hold_clear; // see RL9 see RL12 see RL10 see RL11

  // service keeps only the four lowest stages (see RL6)
  assign next_prescaler = full_clear     ? '0 :
                          clears.service ? (prescaler & KEEP_MASK) :
                                           prescaler + PRESCALER_W'(1);

  // counter clears on reset, hold or service, freezes in stop (see RL5 see RL19 see RL21)
  assign next_count = (clears.internal_reset | clears.hold_clear) ? '0 :
                      clears.service                            ? '0 :
                      clears.stop_mode                          ? count :
                      tick                                      ? count + COUNTER_W'(1) :
                                                                  count;

  // chain registers on the crystal clock only (see RL2)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescaler <= '0;
      count     <= '0;
    end else begin
      prescaler <= next_prescaler;
      count     <= next_count;
    end
  end

endmodule : timeout_counter

// ### hdl/wdog_pkg.sv
// shared constants, field layouts and carrier types of the runaway code watchdog
package wdog_pkg;

  // bus and datapath widths
  localparam int ADDR_W      = 18;          // byte address width of the register port
  localparam int DATA_W      = 32;          // bus data width
  localparam int PRESCALER_W = 12;          // shared prescaler stages
  localparam int COUNTER_W   = 6;           // watchdog counter stages

  // register map: the service register index counts words, so byte address = index * 4
  localparam logic [15:0]       SERVICE_INDEX = 16'hffff;
  localparam logic [ADDR_W-1:0] SERVICE_ADDR  = {SERVICE_INDEX, 2'b00};
  localparam logic [ADDR_W-1:0] CONTROL_ADDR  = 18'h00000;
  localparam logic [ADDR_W-1:0] STATUS_ADDR   = 18'h00004;

  // control register fields and reset values
  localparam int   CTRL_DISABLE_BIT = 0;    // watchdog_disable_opt
  localparam int   CTRL_RATE_BIT    = 1;    // timeout_rate_select, 1 selects the long timeout
  localparam logic CTRL_DISABLE_RST = 1'b0;
  localparam logic CTRL_RATE_RST    = 1'b0;

  // status register fields
  localparam int STAT_CAUSE_BIT    = 0;     // reset_cause_status watchdog flag, write 1 to clear
  localparam int STAT_ACTIVE_BIT   = 1;     // reset pulse in progress
  localparam int STAT_DISABLED_BIT = 2;     // watchdog held off
  localparam int STAT_PIN_BIT      = 3;     // sampled level of the reset pin
  localparam int STAT_COUNT_LSB    = 8;     // watchdog counter value
  localparam int STAT_PRESC_LSB    = 16;    // prescaler value

  // response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // timing in crystal clock cycles
  localparam int SHORT_PERIOD         = 128;     // prescaler tap for the short timeout
  localparam int LONG_PERIOD          = 4096;    // prescaler tap for the long timeout
  localparam int SHORT_TIMEOUT_CYCLES = 8176;
  localparam int LONG_TIMEOUT_CYCLES  = 262128;
  localparam int TIMEOUT_TRIM = (1 << COUNTER_W) * SHORT_PERIOD - SHORT_TIMEOUT_CYCLES;
  localparam int SERVICE_CLEAR_LSB    = 4;       // service clears prescaler stages 12..5
  localparam int RESET_PIN_CYCLES     = 32;      // reset pin low time
  localparam int POR_CLEAR_CYCLES     = 4096;    // prescaler clear after power-up

  // control carrier
  typedef struct packed {
    logic rate_long;                        // long timeout selected
    logic disable_opt;                      // software disable
  } wdog_ctrl_t;

  // clear requests into the counter chain
  typedef struct packed {
    logic stop_mode;                        // crystal removed, prescaler cleared
    logic vector_fetch;                     // reset vector on the bus
    logic por_clear;                        // power-up clear
    logic internal_reset;                   // any internal reset
    logic hold_clear;                       // disabled or reset pulse running
    logic service;                          // service write
  } wdog_clear_t;

  // counter chain state
  typedef struct packed {
    logic [PRESCALER_W-1:0] prescaler;
    logic [COUNTER_W-1:0]   count;
    logic                   timeout;        // overflow point reached
  } wdog_count_t;

  // register selector
  typedef enum logic [1:0] {
    SEL_NONE    = 2'b00,
    SEL_CONTROL = 2'b01,
    SEL_STATUS  = 2'b10,
    SEL_SERVICE = 2'b11
  } reg_sel_t;

  // watchdog sequencer states
  typedef enum logic [1:0] {
    ST_COUNTING  = 2'b00,
    ST_DISABLED  = 2'b01,
    ST_RESET_OUT = 2'b10
  } wd_state_t;

endpackage : wdog_pkg

// ### sim/reset_pin_model.sv
// pulled-up reset pin between the watchdog and the system reset logic
`timescale 1ns/1ps
module reset_pin_model (
  input  wire logic drive_o,
  input  wire logic drive_oe,
  output logic      level
);
  // a released pin floats back to the pull-up level
  assign level = drive_oe ? drive_o : 1'b1;
endmodule : reset_pin_model

// ### sim/runaway_code_watchdog_bench.sv
// self-checking bench of the runaway code watchdog
`timescale 1ns/1ps
module runaway_code_watchdog_bench;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [17:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic [4:0]  mode = 0;  // stop, break, monitor, irq voltage, pin voltage
  logic [4:0]  pat [5] = '{5'h00, 5'h06, 5'h05, 5'h09, 5'h10};
  logic awready, wready, arready, rvalid, bvalid, pin, reset_pin_o, reset_pin_oe;
  logic system_reset, watchdog_cause, seen = 0, vector_fetch = 0, internal_reset = 0;
  int n_fail = 0, checks = 0, cyc = 0, n;
  always #2.5 aclk = ~aclk;
  runaway_code_watchdog #(.POR_CLEAR_CYCLES(8), .RESET_VECTOR_LOW(8'h5a)) u_runaway_code_watchdog (
    .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .stop_mode(mode[4]), .vector_fetch, .internal_reset,
    .monitor_mode(mode[2]), .break_state(mode[3]), .test_high_voltage_on_reset(mode[0]),
    .test_high_voltage_on_irq(mode[1]), .reset_pin_i(pin), .reset_pin_o, .reset_pin_oe,
    .system_reset, .watchdog_cause);
  reset_pin_model u_reset_pin_model (.drive_o(reset_pin_o), .drive_oe(reset_pin_oe), .level(pin));
  task automatic end_of_test;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  // cycle limit and sticky record of any reset pulse
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (system_reset === 1'b1) seen <= 1;
    if (cyc == 90000) begin n_fail++; end_of_test; end
  end
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin n_fail++; $display("mismatch %s expected %h seen %h", s, e, g); end
  endtask : chk
  task automatic wr(logic [17:0] a, logic [31:0] v);
    logic ta = 0, tw = 0;
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1;
    while (!(ta && tw)) begin
      @(posedge aclk);
      if (awvalid && awready) begin ta = 1; awvalid <= 0; end
      if (wvalid && wready) begin tw = 1; wvalid <= 0; end
    end
    bready <= 1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp; bready <= 0;
  endtask : wr
  task automatic rd(logic [17:0] a);
    araddr <= a; arvalid <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0; rready <= 1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata; r = rresp; rready <= 0;
  endtask : rd
  task automatic t_regs;
    rd(wdog_pkg::CONTROL_ADDR); chk("control", 0, d);
    wr(wdog_pkg::CONTROL_ADDR, 2); rd(wdog_pkg::CONTROL_ADDR); chk("rate", 2, d);
    wr(wdog_pkg::CONTROL_ADDR, 0); rd(wdog_pkg::SERVICE_ADDR); chk("vector", 8'h5a, d);
    wr(wdog_pkg::SERVICE_ADDR, 0); chk("service", wdog_pkg::RESP_OKAY, r);
    rd(18'h00100); chk("unmapped", wdog_pkg::RESP_SLVERR, r);
    $display("t_regs done");
  endtask : t_regs
  // one-cycle clear pulses and the long rate, judged from the status counter fields
  task automatic t_clears;
    wr(wdog_pkg::SERVICE_ADDR, 0); repeat (300) @(posedge aclk);
    internal_reset <= 1; @(posedge aclk); internal_reset <= 0; rd(wdog_pkg::STATUS_ADDR);
    chk("int count", 0, d[13:8]); chk("int presc", 1, d[27:16] < 4);
    repeat (300) @(posedge aclk);
    vector_fetch <= 1; @(posedge aclk); vector_fetch <= 0; rd(wdog_pkg::STATUS_ADDR);
    chk("fetch count", 2, d[13:8]); chk("fetch presc", 1, d[27:16] < 4);
    wr(wdog_pkg::CONTROL_ADDR, 2); wr(wdog_pkg::SERVICE_ADDR, 0); repeat (300) @(posedge aclk);
    rd(wdog_pkg::STATUS_ADDR); chk("long count", 0, d[13:8]);
    wr(wdog_pkg::CONTROL_ADDR, 0);
    $display("t_clears done");
  endtask : t_clears
  task automatic t_timeout;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      while (system_reset !== 1'b1) begin @(posedge aclk); n++; end
      if (k) chk("timeout", wdog_pkg::SHORT_TIMEOUT_CYCLES + 1, n);
      n = 0;
      while (system_reset === 1'b1) begin chk("pin", 0, pin); @(posedge aclk); n++; end
      chk("pulse", 32, n); chk("cause", 1, watchdog_cause);
    end
    wr(wdog_pkg::STATUS_ADDR, 1); chk("clear", 0, watchdog_cause);
    $display("t_timeout done");
  endtask : t_timeout
  task automatic t_modes;
    seen = 0;
    repeat (4) begin repeat (5000) @(posedge aclk); wr(wdog_pkg::SERVICE_ADDR, 32'hffffffff); end
    chk("serviced", 0, seen);
    for (int k = 0; k < 5; k++) begin
      wr(wdog_pkg::SERVICE_ADDR, k);
      if (k == 0) wr(wdog_pkg::CONTROL_ADDR, 1);
      mode <= pat[k]; seen = 0;
      repeat (8500) @(posedge aclk);
      chk("held", 0, seen);
      mode <= 0; if (k == 0) wr(wdog_pkg::CONTROL_ADDR, 0);
    end
    $display("t_modes done");
  endtask : t_modes
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    t_regs; t_clears; t_timeout; t_modes; end_of_test;
  end
endmodule : runaway_code_watchdog_bench

// ### sim/watchdog_properties.sv
// assertion checker bound to the watchdog top
`timescale 1ns/1ps
module watchdog_props #(parameter int RESET_PIN_CYCLES = 32) (
  input wire logic        aclk, aresetn, awvalid, awready, bvalid, bready, rvalid, rready,
  input wire logic [1:0]  bresp,
  input wire logic [31:0] rdata,
  input wire logic        reset_pin_o, reset_pin_oe, system_reset, watchdog_cause
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int cnt;  // cycles the reset pulse has stood
  always_ff @(posedge aclk) cnt <= (aresetn && system_reset) ? cnt + 1 : 0;
  a_pulse_len: assert property ($fell(system_reset) |-> cnt == RESET_PIN_CYCLES)
    else $error("pulse length");
  a_pin_follows: assert property (reset_pin_oe == system_reset)
    else $error("pin enable");
  a_pin_low: assert property (reset_pin_oe |-> !reset_pin_o)
    else $error("pin level");
  a_cause_set: assert property ($rose(system_reset) |-> watchdog_cause)
    else $error("cause flag");
  a_aw_busy: assert property (awvalid && awready |=> !awready)
    else $error("aw ready");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("b hold");
  a_b_done: assert property (bvalid && bready |=> !bvalid)
    else $error("b done");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("r hold");
  c_reset: cover property ($rose(system_reset));
  c_write: cover property (bvalid && bready);
  c_read: cover property (rvalid && rready);
endmodule : watchdog_props
bind runaway_code_watchdog watchdog_props #(.RESET_PIN_CYCLES(RESET_PIN_CYCLES)) u_props (.aclk,
  .aresetn, .awvalid, .awready, .bvalid, .bready, .rvalid, .rready, .bresp, .rdata, .reset_pin_o,
  .reset_pin_oe, .system_reset, .watchdog_cause);
